// file: mac_rx_control_tx_status.sv
// transmit status word, receive control word, receive queue and pause hold
// Notes on behaviour
// (R1) status word at 0x72 holds last sent frame's result, replaced per frame
// (R2) bit 13 set when the frame suffered a late collision
// (R3) bit 12 set when the frame reached the collision limit
// (R4) bits 5..0 carry the frame tag; other bits describe that frame
// (R5) while flush bit 15 is set, queue is cleared and pointers reset
// (R6) host clears receive enable before flushing, then clears flush again
// (R7) with bit 14 set, UDP frames with bad checksum are dropped
// (R8) with bit 13 set, TCP frames with bad checksum are dropped
// (R9) with bit 12 set, IP frames with bad header checksum are dropped
// (R10) bit 11 accepts unicast passing the MAC filter; resets to one
// (R11) full duplex with bit 10: pause frames hold transmit until timer ends
// (R12) host keeps bit 10 clear in half duplex, where it does nothing
// (R13) bit 9 keeps CRC error frames; clear drops them all
// (R14) bit 8 accepts multicast passing the MAC filter
// (R15) bit 7 accepts every broadcast frame
// (R16) bit 6 accepts every multicast frame, broadcast too
// (R17) bit 5 accepts unicast matching the station address
// (R18) bit 4 accepts every frame whatever its destination
// (R19) bit 1 inverts the sense of the destination check
// (R20) bit 0 runs receive; clearing stops after the current frame ends
// (R21) both collision flags are replaced whenever a new status is recorded
// (R22) all checks finish before a frame becomes visible in the queue
module mac_rx_control_tx_status
    import mac_ctrl_pkg::*;
#(
    parameter int QUEUE_BYTES = RX_QUEUE_BYTES,
    parameter int QADDR_W = $clog2(RX_QUEUE_BYTES)
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // register port behind the serial host interface
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [1:0] reg_be_i,
    input wire logic [REG_DATA_W-1:0] reg_wdata_i,
    output logic [REG_DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // transmit completion from the transmit engine
    input wire logic tx_done_i,
    input wire logic tx_late_coll_i,
    input wire logic tx_max_coll_i,
    input wire logic [SENT_TAG_W-1:0] tx_tag_i,
    // pause control towards the transmit engine
    input wire logic full_duplex_i,
    input wire logic speed_100_i,
    input wire logic rx_pause_i,
    input wire logic [15:0] rx_pause_quanta_i,
    output logic tx_hold_o,
    // received byte stream with end-of-frame classification
    input wire logic rx_valid_i,
    input wire logic rx_sof_i,
    input wire logic rx_eof_i,
    input wire logic [7:0] rx_data_i,
    input wire logic dst_bcast_i,
    input wire logic dst_mcast_i,
    input wire logic dst_station_match_i,
    input wire logic dst_filter_pass_i,
    input wire logic crc_err_i,
    input wire logic ip_frame_i,
    input wire logic ip_sum_bad_i,
    input wire logic tcp_frame_i,
    input wire logic tcp_sum_bad_i,
    input wire logic udp_frame_i,
    input wire logic udp_sum_bad_i,
    // host side of the receive queue
    input wire logic q_rd_i,
    output logic [7:0] q_rd_data_o,
    output logic q_rd_valid_o,
    output logic [QADDR_W:0] q_bytes_o,
    output logic [15:0] q_frames_o,
    output logic rx_running_o,
    output logic frame_drop_o
);
    logic [15:0] tx_frame_status;
    logic [15:0] rx_control_primary;
    logic [7:0] receive_queue [QUEUE_BYTES];
    rx_state_t state;
    logic rx_run;
    logic [QADDR_W-1:0] cur_ptr;
    logic [QADDR_W-1:0] rd_ptr;
    logic [QADDR_W-1:0] clr_idx;
    logic [QADDR_W:0] used;
    logic [QADDR_W:0] cur_len;
    logic [15:0] pause_left;
    logic [QUANTUM_CNT_W-1:0] quantum_cnt;
    logic quantum_tick;
    logic frame_ok;
    logic flush;
    logic end_frame;
    logic commit;
    logic pop;
    logic store;
    logic room;

    function automatic logic [QADDR_W-1:0] ptr_inc(
        input logic [QADDR_W-1:0] p);
        if (p == QADDR_W'(QUEUE_BYTES - 1))
            return '0;
        return p + 1'b1;
    endfunction

    assign flush = rx_control_primary[RX_QUEUE_FLUSH_BIT];
    assign end_frame = rx_valid_i && rx_eof_i && state == RX_RECV;
    assign room = (used + cur_len) < (QADDR_W+1)'(QUEUE_BYTES);
    assign store = rx_valid_i && (state == RX_RECV ||
                   (rx_sof_i && rx_run && !flush)) && room && !flush;
    // a frame only commits once every check has been made
    assign commit = end_frame && frame_ok && room && !flush; // [R22]
    assign pop = q_rd_i && used != '0 && !flush;

    rx_frame_judge judge (
        .ctrl_i(rx_control_primary),
        .dst_bcast_i(dst_bcast_i),
        .dst_mcast_i(dst_mcast_i),
        .dst_station_match_i(dst_station_match_i),
        .dst_filter_pass_i(dst_filter_pass_i),
        .crc_err_i(crc_err_i),
        .ip_frame_i(ip_frame_i),
        .ip_sum_bad_i(ip_sum_bad_i),
        .tcp_frame_i(tcp_frame_i),
        .tcp_sum_bad_i(tcp_sum_bad_i),
        .udp_frame_i(udp_frame_i),
        .udp_sum_bad_i(udp_sum_bad_i),
        .frame_ok_o(frame_ok)
    );

    // host writes to the receive control word, byte lanes honoured
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_control_primary <= RX_CONTROL_PRIMARY_RST; // [R10]
        end else if (reg_wr_i && reg_addr_i == RX_CONTROL_PRIMARY_OFS) begin
            if (reg_be_i[0])
                rx_control_primary[7:0] <= reg_wdata_i[7:0];
            if (reg_be_i[1])
                rx_control_primary[15:8] <= reg_wdata_i[15:8];
        end
    end

    // last transmitted frame status, whole word replaced per frame
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_frame_status <= TX_FRAME_STATUS_RST;
        end else if (tx_done_i) begin
            tx_frame_status <= '0; // [R1] [R21]
            tx_frame_status[LATE_COLLISION_BIT] <= tx_late_coll_i; // [R2]
            tx_frame_status[MAX_COLLISION_BIT] <= tx_max_coll_i; // [R3]
            tx_frame_status[SENT_TAG_LSB +: SENT_TAG_W] <= tx_tag_i; // [R4]
        end
    end

    // registered read data, unmapped offsets read zero
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    TX_FRAME_STATUS_OFS: reg_rdata_o <= tx_frame_status;
                    RX_CONTROL_PRIMARY_OFS: reg_rdata_o <= rx_control_primary;
                    default: reg_rdata_o <= '0;
                endcase
            end
        end
    end

    // receive run flag drops only between frames
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            rx_run <= 1'b0;
        else if (rx_control_primary[RX_ENABLE_BIT])
            rx_run <= 1'b1; // [R20]
        else if (state != RX_RECV)
            rx_run <= 1'b0; // [R20]
    end

    // receive frame state machine
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= RX_IDLE;
        end else if (flush) begin
            state <= RX_IDLE; // [R5]
        end else if (rx_valid_i) begin
            case (state)
                RX_IDLE: begin
                    if (rx_sof_i && !rx_eof_i)
                        state <= rx_run ? RX_RECV : RX_DROP;
                end
                RX_RECV: begin
                    if (rx_eof_i)
                        state <= RX_IDLE;
                end
                RX_DROP: begin
                    if (rx_eof_i)
                        state <= RX_IDLE;
                end
                default: state <= RX_IDLE;
            endcase
        end
    end

    // queue memory: swept to zero during flush, else frame bytes written
    always_ff @(posedge ref_clk_i) begin
        if (flush)
            receive_queue[clr_idx] <= 8'h00; // [R5]
        else if (store)
            receive_queue[cur_ptr] <= rx_data_i;
    end

    // pointers and counts of the receive queue
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_ptr <= '0;
            rd_ptr <= '0;
            clr_idx <= '0;
            used <= '0;
            cur_len <= '0;
            q_frames_o <= '0;
        end else if (flush) begin
            cur_ptr <= '0; // [R5]
            rd_ptr <= '0;
            used <= '0;
            cur_len <= '0;
            q_frames_o <= '0;
            clr_idx <= ptr_inc(clr_idx);
        end else begin
            clr_idx <= '0;
            if (pop)
                rd_ptr <= ptr_inc(rd_ptr);
            used <= used - (QADDR_W+1)'(pop) + (commit ? cur_len + 1'b1 : '0);
            if (commit)
                q_frames_o <= q_frames_o + 1'b1;
            if (end_frame || (rx_valid_i && rx_sof_i)) begin
                // rewind over a dropped frame, keep a committed one
                cur_ptr <= commit ? ptr_inc(cur_ptr) : QADDR_W'(cur_ptr
                    + (cur_ptr < cur_len ? QUEUE_BYTES : 0) - cur_len);
                cur_len <= '0;
                if (store && !rx_eof_i) begin
                    cur_ptr <= ptr_inc(cur_ptr);
                    cur_len <= (QADDR_W+1)'(1);
                end
            end else if (store) begin
                cur_ptr <= ptr_inc(cur_ptr);
                cur_len <= cur_len + 1'b1;
            end
        end
    end

    // host byte reads from the committed part of the queue
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_rd_data_o <= 8'h00;
            q_rd_valid_o <= 1'b0;
        end else begin
            q_rd_valid_o <= pop;
            if (pop)
                q_rd_data_o <= receive_queue[rd_ptr];
        end
    end

    // marks frames received in RX_RECV that end without being kept; frames ignored while stopped are not marked
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            frame_drop_o <= 1'b0;
        else
            frame_drop_o <= end_frame && !commit;
    end

    // one-cycle tick per pause quantum at the current speed
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quantum_cnt <= '0;
            quantum_tick <= 1'b0;
        end else begin
            quantum_tick <= 1'b0;
            if (quantum_cnt == '0) begin
                quantum_tick <= 1'b1;
                quantum_cnt <= speed_100_i
                    ? QUANTUM_CNT_W'(QUANTUM_CYC_100M - 1)
                    : QUANTUM_CNT_W'(QUANTUM_CYC_10M - 1);
            end else begin
                quantum_cnt <= quantum_cnt - 1'b1;
            end
        end
    end

    // pause timer loaded by received pause frames in full duplex
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            pause_left <= '0;
        else if (!full_duplex_i || !rx_control_primary[PAUSE_HONOUR_BIT])
            pause_left <= '0; // [R11]
        else if (rx_pause_i)
            pause_left <= rx_pause_quanta_i; // [R11]
        else if (quantum_tick && pause_left != '0)
            pause_left <= pause_left - 1'b1;
    end

    assign tx_hold_o = pause_left != '0; // [R11]
    assign q_bytes_o = used;
    assign rx_running_o = rx_run;

    sequence stop_req_s;
        !rx_control_primary[RX_ENABLE_BIT] && state != RX_RECV;
    endsequence

    late_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R2]
        tx_done_i |=> tx_frame_status[LATE_COLLISION_BIT] == $past(tx_late_coll_i))
        else $error("late collision flag wrong");
    max_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R3]
        tx_done_i |=> tx_frame_status[MAX_COLLISION_BIT] == $past(tx_max_coll_i))
        else $error("max collision flag wrong");
    sent_tag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R4]
        tx_done_i |=> tx_frame_status[5:0] == $past(tx_tag_i)
        && tx_frame_status[15:14] == 2'b00)
        else $error("sent frame tag wrong");
    status_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R1]
        !tx_done_i |=> $stable(tx_frame_status))
        else $error("status changed without a frame");
    flags_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R21]
        tx_done_i && !tx_late_coll_i && !tx_max_coll_i
        |=> tx_frame_status[13:12] == 2'b00)
        else $error("stale collision flag kept");
    flush_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R5]
        flush |=> used == '0 && rd_ptr == '0 && cur_ptr == '0)
        else $error("flush left queue state");
    crc_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R13]
        end_frame && crc_err_i && !rx_control_primary[CRC_ERR_ACCEPT_BIT]
        |-> !commit ##1 frame_drop_o)
        else $error("crc error frame kept");
    commit_ok_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R22]
        commit |=> used >= $past(used) + 16'd1 - 16'($past(pop)))
        else $error("commit did not publish frame");
    pause_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R11]
        rx_pause_i && full_duplex_i && rx_control_primary[PAUSE_HONOUR_BIT]
        && rx_pause_quanta_i > 16'd1 |=> tx_hold_o [*2])
        else $error("pause frame not honoured");
    stop_after_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R20]
        stop_req_s |=> !rx_run)
        else $error("receive did not stop");
    run_in_frame_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [R20]
        state == RX_RECV |-> rx_run)
        else $error("receive stopped inside a frame");
endmodule

// file: mac_ctrl_pkg.sv
// constants for the transmit status and receive control registers
package mac_ctrl_pkg;
    // register map and widths
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 16;
    localparam logic [7:0] TX_FRAME_STATUS_OFS = 8'h72;
    localparam logic [7:0] RX_CONTROL_PRIMARY_OFS = 8'h74;
    localparam logic [15:0] TX_FRAME_STATUS_RST = 16'h0000;
    localparam logic [15:0] RX_CONTROL_PRIMARY_RST = 16'h0800;
    // transmit status fields
    localparam int LATE_COLLISION_BIT = 13;
    localparam int MAX_COLLISION_BIT = 12;
    localparam int SENT_TAG_LSB = 0;
    localparam int SENT_TAG_W = 6;
    // receive control fields
    localparam int RX_QUEUE_FLUSH_BIT = 15;
    localparam int UDP_CHECK_BIT = 14;
    localparam int TCP_CHECK_BIT = 13;
    localparam int IP_CHECK_BIT = 12;
    localparam int UNICAST_FILTER_BIT = 11;
    localparam int PAUSE_HONOUR_BIT = 10;
    localparam int CRC_ERR_ACCEPT_BIT = 9;
    localparam int MULTICAST_FILTER_BIT = 8;
    localparam int BROADCAST_ACCEPT_BIT = 7;
    localparam int ALL_MULTICAST_BIT = 6;
    localparam int UNICAST_ACCEPT_BIT = 5;
    localparam int PROMISCUOUS_BIT = 4;
    localparam int INVERSE_FILTER_BIT = 1;
    localparam int RX_ENABLE_BIT = 0;
    // receive queue size in bytes
    localparam int RX_QUEUE_BYTES = 12288;
    // pause quantum timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int PAUSE_QUANTUM_BITS = 512;
    localparam int BIT_TIME_NS_100M = 10;
    localparam int BIT_TIME_NS_10M = 100;
    localparam int QUANTUM_CYC_100M =
        (PAUSE_QUANTUM_BITS * BIT_TIME_NS_100M) / CLK_PERIOD_NS;
    localparam int QUANTUM_CYC_10M =
        (PAUSE_QUANTUM_BITS * BIT_TIME_NS_10M) / CLK_PERIOD_NS;
    localparam int QUANTUM_CNT_W = 12;
    // receive engine states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_RECV = 2'b01,
        RX_DROP = 2'b10
    } rx_state_t;
endpackage

// file: rx_frame_judge.sv
// decides whether a finished receive frame is kept or discarded
module rx_frame_judge
    import mac_ctrl_pkg::*;
(
    input wire logic [15:0] ctrl_i,
    input wire logic dst_bcast_i,
    input wire logic dst_mcast_i,
    input wire logic dst_station_match_i,
    input wire logic dst_filter_pass_i,
    input wire logic crc_err_i,
    input wire logic ip_frame_i,
    input wire logic ip_sum_bad_i,
    input wire logic tcp_frame_i,
    input wire logic tcp_sum_bad_i,
    input wire logic udp_frame_i,
    input wire logic udp_sum_bad_i,
    output logic frame_ok_o
);
    logic addr_raw;
    logic addr_ok;
    logic checks_ok;

    // destination address check
    always_comb begin
        addr_raw = 1'b0;
        if (dst_bcast_i && ctrl_i[BROADCAST_ACCEPT_BIT])
            addr_raw = 1'b1; // [R15]
        if (dst_mcast_i && ctrl_i[ALL_MULTICAST_BIT])
            addr_raw = 1'b1; // [R16]
        if (dst_mcast_i && !dst_bcast_i && dst_filter_pass_i
            && ctrl_i[MULTICAST_FILTER_BIT])
            addr_raw = 1'b1; // [R14]
        if (!dst_mcast_i && dst_station_match_i
            && ctrl_i[UNICAST_ACCEPT_BIT])
            addr_raw = 1'b1; // [R17]
        if (!dst_mcast_i && dst_filter_pass_i
            && ctrl_i[UNICAST_FILTER_BIT])
            addr_raw = 1'b1; // [R10]
        // inverse sense flips the address result
        addr_ok = addr_raw ^ ctrl_i[INVERSE_FILTER_BIT]; // [R19]
        if (ctrl_i[PROMISCUOUS_BIT])
            addr_ok = 1'b1; // [R18]
    end

    // integrity checks: checksum ones only when enabled, CRC unless bit 9 accepts errors
    always_comb begin
        checks_ok = 1'b1;
        if (crc_err_i && !ctrl_i[CRC_ERR_ACCEPT_BIT])
            checks_ok = 1'b0; // [R13]
        if (udp_frame_i && udp_sum_bad_i && ctrl_i[UDP_CHECK_BIT])
            checks_ok = 1'b0; // [R7]
        if (tcp_frame_i && tcp_sum_bad_i && ctrl_i[TCP_CHECK_BIT])
            checks_ok = 1'b0; // [R8]
        if (ip_frame_i && ip_sum_bad_i && ctrl_i[IP_CHECK_BIT])
            checks_ok = 1'b0; // [R9]
    end

    assign frame_ok_o = addr_ok && checks_ok;
endmodule

// file: link_partner.sv
// link partner model that drives the received byte stream
module link_partner (
    input wire logic clk_i,
    output logic valid_o,
    output logic sof_o,
    output logic eof_o,
    output logic [7:0] data_o,
    output logic [10:0] cls_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        valid_o = 1'b0;
        sof_o = 1'b0;
        eof_o = 1'b0;
        data_o = 8'h00;
        cls_o = 11'h000;
    end
    // one frame, sof to eof; class word is true only on the eof byte
    task automatic send(input int n, input logic [7:0] base,
            input logic [10:0] cls);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            valid_o = 1'b1;
            sof_o = (i == 0);
            eof_o = (i == n - 1);
            data_o = base + 8'(i);
            cls_o = (i == n - 1) ? cls : ~cls;
        end
        @(negedge clk_i);
        // released data and class lines show inverted values so stale data never matches
        valid_o = 1'b0;
        sof_o = 1'b0;
        eof_o = 1'b0;
        data_o = ~data_o;
        cls_o = ~cls_o;
    endtask
endmodule

// file: tb_top.sv
// self-checking bench for the status and receive control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0, rd = 1'b0, done = 1'b0, late = 1'b0, maxc = 1'b0;
    logic [1:0] be = 2'h3;
    logic [15:0] wdata = 16'h0000, rdata, quanta = 16'h0000, frames;
    logic [5:0] tag = 6'h00;
    logic fd = 1'b0, spd = 1'b1, pause = 1'b0, qrd = 1'b0;
    logic rvalid, hold, qvalid, running, drop, val, sof, eof;
    logic [7:0] data, qdata;
    logic [10:0] cls;
    logic [6:0] qbytes;
    int miscompares = 0, check_count = 0, seed = 46098, mf = 0, n, t;
    logic [7:0] mq[$];
    logic [26:0] cases[18] = '{
        {16'h0011, 11'h000}, {16'h0011, 11'h010}, {16'h0211, 11'h010},
        {16'h4011, 11'h003}, {16'h0011, 11'h003}, {16'h2011, 11'h00c},
        {16'h1011, 11'h060}, {16'h0081, 11'h600}, {16'h0001, 11'h600},
        {16'h0041, 11'h200}, {16'h0041, 11'h600}, {16'h0021, 11'h100},
        {16'h0021, 11'h000}, {16'h0023, 11'h100}, {16'h0023, 11'h000},
        {16'h0801, 11'h080}, {16'h0101, 11'h280}, {16'h0001, 11'h280}};
    always #10 clk = ~clk;
    mac_rx_control_tx_status #(.QUEUE_BYTES(64), .QADDR_W(6))
        u_mac_rx_control_tx_status (.ref_clk_i(clk), .rstn_i(rstn),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_be_i(be),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .tx_done_i(done), .tx_late_coll_i(late), .tx_max_coll_i(maxc),
        .tx_tag_i(tag), .full_duplex_i(fd), .speed_100_i(spd),
        .rx_pause_i(pause), .rx_pause_quanta_i(quanta), .tx_hold_o(hold),
        .rx_valid_i(val), .rx_sof_i(sof), .rx_eof_i(eof), .rx_data_i(data),
        .dst_bcast_i(cls[10]), .dst_mcast_i(cls[9]),
        .dst_station_match_i(cls[8]), .dst_filter_pass_i(cls[7]),
        .crc_err_i(cls[6]), .ip_frame_i(cls[5]), .ip_sum_bad_i(cls[4]),
        .tcp_frame_i(cls[3]), .tcp_sum_bad_i(cls[2]),
        .udp_frame_i(cls[1]), .udp_sum_bad_i(cls[0]), .q_rd_i(qrd),
        .q_rd_data_o(qdata), .q_rd_valid_o(qvalid), .q_bytes_o(qbytes),
        .q_frames_o(frames), .rx_running_o(running), .frame_drop_o(drop));
    link_partner u_link_partner (.clk_i(clk), .valid_o(val), .sof_o(sof),
        .eof_o(eof), .data_o(data), .cls_o(cls));
    // reference decision: address check, inversion, then frame checks
    function automatic bit keep(logic [15:0] c, logic [10:0] k);
        bit a;
        a = (k[10] & c[7]) | (k[9] & c[6]) | (!k[9] & k[8] & c[5])
            | (!k[9] & k[7] & c[11]) | (k[9] & k[7] & c[8]);
        a = (c[1] ? !a : a) | c[4];
        return a & (!k[6] | c[9]) & !(k[5] & k[4] & c[12])
            & !(k[3] & k[2] & c[13]) & !(k[1] & k[0] & c[14]);
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(32'(rvalid), 1);
        chk(32'(rdata), 32'(e));
    endtask
    // one frame through the partner, model updated, counts compared
    task automatic frame(input logic [15:0] c, input logic [10:0] k);
        logic [7:0] b;
        b = 8'($random(seed));
        u_link_partner.send(3, b, k);
        chk(32'(drop), 32'(!keep(c, k)));
        if (keep(c, k)) begin
            for (int i = 0; i < 3; i++) mq.push_back(b + 8'(i));
            mf++;
        end
        @(negedge clk);
        chk(32'(qbytes), mq.size());
        chk(32'(frames), mf);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        rreg(8'h74, 16'h0800);
        rreg(8'h72, 16'h0000);
        rreg(8'h10, 16'h0000);
        be = 2'h1; // low lane only, the upper byte keeps its reset value
        wreg(8'h74, 16'h5aa5);
        be = 2'h3;
        rreg(8'h74, 16'h08a5);
        wreg(8'h72, 16'hffff);
        rreg(8'h72, 16'h0000);
        // two finishing frames back to back; the later one must win
        for (int i = 0; i < 8; i++) begin
            t = $random(seed);
            @(negedge clk);
            done = 1'b1;
            {late, maxc, tag} = t[7:0];
            @(negedge clk);
            {late, maxc, tag} = t[15:8];
            @(negedge clk);
            done = 1'b0;
            rreg(8'h72, {2'b00, t[15:14], 6'h00, t[13:8]});
        end
        foreach (cases[i]) begin
            wreg(8'h74, cases[i][26:11]);
            frame(cases[i][26:11], cases[i][10:0]);
        end
        // drain in order, then one refused pop on the empty queue
        for (int i = mq.size(); i >= 0; i--) begin
            @(negedge clk);
            qrd = 1'b1;
            @(negedge clk);
            qrd = 1'b0;
            chk(32'(qvalid), i > 0);
            if (i > 0) chk(32'(qdata), 32'(mq.pop_front()));
        end
        // disable in mid-frame: the frame ends normally, the next is ignored
        wreg(8'h74, 16'h0011);
        chk(32'(running), 1);
        fork
            frame(16'h0011, 11'h000);
            wreg(8'h74, 16'h0010);
        join
        chk(32'(running), 0);
        u_link_partner.send(3, 8'h40, 11'h000);
        chk(32'(drop), 0);
        @(negedge clk);
        chk(32'(qbytes), mq.size());
        wreg(8'h74, 16'h8010);
        repeat (70) @(negedge clk);
        mq.delete();
        mf = 0;
        chk(32'(qbytes), 0);
        chk(32'(frames), 0);
        wreg(8'h74, 16'h0000);
        // pause of two quanta: 100 Mb/s, flow control off, then 10 Mb/s
        fd = 1'b1;
        for (int m = 0; m < 3; m++) begin
            spd = (m != 2);
            wreg(8'h74, (m == 1) ? 16'h0000 : 16'h0400);
            @(negedge clk);
            pause = 1'b1;
            quanta = 16'h0002;
            @(negedge clk);
            pause = 1'b0;
            chk(32'(hold), m != 1);
            n = 0;
            while (hold !== 1'b0 && n < 6000) begin
                @(negedge clk);
                n++;
            end
            chk(32'(m == 1 ? n == 0 : m == 0 ? n >= 255 && n <= 513
                : n >= 2559 && n <= 5121), 1);
        end
        wreg(8'h74, 16'h0000);
        fd = 1'b0; // half duplex only with flow control off
        report_and_stop();
    end
    initial begin
        repeat (20000) @(negedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
